// >>> gpp_top.sv
/*
  Single GPIO pin cell: mode, output buffer, pull, drive, alternate
  function hand-off and interrupt trigger, behind a plain register port.
  Assumes one clock, a synchronous active-low reset, and a pad whose
  level is worked out outside from pad_out and pad_oe.
*/
`timescale 1ns/1ps
`default_nettype none
`include "gpp_consts.svh"
module gpp_top #(
  parameter int DATA_W = 32,
  parameter int PRIO_W = 3
) (
  // Clock, reset, enable
  input wire logic clock,
  input wire logic reset_n,
  input wire logic ce,
  // Register port
  input wire logic [`GPP_ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [DATA_W-1:0] rdata,
  // Pad
  input wire logic pad_in,
  output logic pad_out,
  output logic pad_oe,
  output logic pull_up_en,
  output logic pull_down_en,
  output gpp_pkg::gpp_drive_t drive_code,
  // Alternate function peripheral
  input wire logic alt_data,
  input wire logic alt_drive_en,
  output logic alt_attached,
  // Interrupt request to the system
  output logic irq_req,
  output logic [PRIO_W-1:0] irq_prio,
  output logic wake_idle_en,
  output logic wake_sleep_en,
  output logic wake_from_deep_doze
);
  import gpp_pkg::*;

  // Parameter checks
  if (DATA_W < `GPP_WAKE_LSB + `GPP_WAKE_W || DATA_W < `GPP_PRIO_LSB + PRIO_W) begin : g_bad_w
    $error("gpp_top data width too narrow for its fields");
  end
  if (PRIO_W < 1 || PRIO_W > 4) begin : g_bad_p
    $error("gpp_top priority width must be 1 to 4");
  end

  gpp_mode_t mode_r;
  gpp_pull_t pull_r;
  gpp_drive_t drive_r;
  logic out_buf_r;
  logic [`GPP_TRIG_W-1:0] trig_r;
  logic [PRIO_W-1:0] prio_r;
  logic [`GPP_WAKE_W-1:0] wake_r;
  logic [DATA_W-1:0] rdata_r;
  logic [DATA_W-1:0] rd_word;
  logic pad_sync;
  logic wr_ctrl, wr_out, wr_tog, wr_cfg, wr_stat;

  gpp_trig_if tif ();

  // Address match shared by write and read decoding
  function automatic logic reg_hit(input logic [`GPP_ADDR_W-1:0] a,
                                   input logic [`GPP_ADDR_W-1:0] ofs);
    reg_hit = (a == ofs);
  endfunction

  // Field legality check for the enum-backed mode field
  function automatic logic mode_ok(input logic [`GPP_MODE_W-1:0] v);
    mode_ok = (v <= GPP_MODE_ALT_OD);
  endfunction

  // Pad input synchroniser
  gpp_sync #(.STAGES(`GPP_SYNC_STAGES)) u_sync (
    .clock(clock),
    .reset_n(reset_n),
    .ce(ce),
    .din(pad_in),
    .dout(pad_sync)
  );

  // Trigger detector
  gpp_trig u_trig (
    .clock(clock),
    .reset_n(reset_n),
    .ce(ce),
    .t(tif.det)
  );

  // Write strobes per register
  assign wr_ctrl = wr_en && reg_hit(addr, `GPP_OFS_CTRL);
  assign wr_out = wr_en && reg_hit(addr, `GPP_OFS_OUT);
  assign wr_tog = wr_en && reg_hit(addr, `GPP_OFS_TOGGLE);
  assign wr_cfg = wr_en && reg_hit(addr, `GPP_OFS_IRQCFG);
  assign wr_stat = wr_en && reg_hit(addr, `GPP_OFS_IRQSTAT);

  // Mode, pull and drive; illegal codes leave the field as it was
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      mode_r <= GPP_MODE_IN;
      pull_r <= GPP_PULL_NONE;
      drive_r <= GPP_DRIVE_LOW;
    end else if (ce && wr_ctrl) begin
      if (mode_ok(wdata[`GPP_MODE_LSB +: `GPP_MODE_W])) begin
        mode_r <= gpp_mode_t'(wdata[`GPP_MODE_LSB +: `GPP_MODE_W]);
      end
      if (wdata[`GPP_PULL_LSB +: `GPP_PULL_W] <= GPP_PULL_DOWN) begin
        pull_r <= gpp_pull_t'(wdata[`GPP_PULL_LSB +: `GPP_PULL_W]);
      end
      if (wdata[`GPP_DRIVE_LSB +: `GPP_DRIVE_W] <= GPP_DRIVE_HIGH) begin
        drive_r <= gpp_drive_t'(wdata[`GPP_DRIVE_LSB +: `GPP_DRIVE_W]);
      end
    end
  end

  // Output buffer, written in every mode; toggle inverts it
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      out_buf_r <= 1'b0;
    end else if (ce) begin
      if (wr_out) begin
        out_buf_r <= |wdata;
      end else if (wr_tog) begin
        out_buf_r <= !out_buf_r;
      end
    end
  end

  // Interrupt configuration
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      trig_r <= `GPP_RST_TRIG;
      prio_r <= PRIO_W'(`GPP_RST_PRIO);
      wake_r <= `GPP_RST_WAKE;
    end else if (ce && wr_cfg) begin
      trig_r <= wdata[`GPP_TRIG_LSB +: `GPP_TRIG_W];
      prio_r <= wdata[`GPP_PRIO_LSB +: PRIO_W];
      wake_r <= wdata[`GPP_WAKE_LSB +: `GPP_WAKE_W];
    end
  end

  // Pad drive from mode and buffer; alternate modes hand over to the peripheral
  always_comb begin
    pad_out = 1'b0;
    pad_oe = 1'b0;
    alt_attached = 1'b0;
    case (mode_r)
      GPP_MODE_IN: begin
        pad_oe = 1'b0;
      end
      GPP_MODE_PP: begin
        pad_out = out_buf_r;
        pad_oe = 1'b1;
      end
      GPP_MODE_OD: begin
        pad_oe = !out_buf_r;
      end
      GPP_MODE_ALT: begin
        alt_attached = 1'b1;
        pad_out = alt_data;
        pad_oe = alt_drive_en;
      end
      GPP_MODE_ALT_OD: begin
        alt_attached = 1'b1;
        pad_oe = alt_drive_en && !alt_data;
      end
      default: begin
        pad_oe = 1'b0;
      end
    endcase
  end

  // Trigger source by mode
  always_comb begin
    case (mode_r)
      GPP_MODE_IN: tif.src = pad_sync;
      GPP_MODE_PP: tif.src = out_buf_r;
      GPP_MODE_OD: tif.src = out_buf_r ? pad_sync : out_buf_r;
      default: tif.src = pad_sync;
    endcase
  end

  assign tif.trig_en = trig_r;
  assign tif.clear = wr_stat && wdata[`GPP_STAT_PEND_BIT];

  // Pad-side static controls
  assign pull_up_en = (pull_r == GPP_PULL_UP);
  assign pull_down_en = (pull_r == GPP_PULL_DOWN);
  assign drive_code = drive_r;

  // Interrupt outputs
  assign irq_req = tif.hit;
  assign irq_prio = prio_r;
  assign wake_idle_en = wake_r[`GPP_WAKE_IDLE];
  assign wake_sleep_en = wake_r[`GPP_WAKE_SLEEP];
  assign wake_from_deep_doze = wake_r[`GPP_WAKE_DEEP];

  // Read word selection; level read always shows the synchronised pad
  always_comb begin
    rd_word = '0;
    if (reg_hit(addr, `GPP_OFS_CTRL)) begin
      rd_word[`GPP_MODE_LSB +: `GPP_MODE_W] = mode_r;
      rd_word[`GPP_PULL_LSB +: `GPP_PULL_W] = pull_r;
      rd_word[`GPP_DRIVE_LSB +: `GPP_DRIVE_W] = drive_r;
    end else if (reg_hit(addr, `GPP_OFS_OUT)) begin
      rd_word[`GPP_OUT_BIT] = out_buf_r;
    end else if (reg_hit(addr, `GPP_OFS_IN)) begin
      rd_word[`GPP_IN_BIT] = pad_sync;
    end else if (reg_hit(addr, `GPP_OFS_IRQCFG)) begin
      rd_word[`GPP_TRIG_LSB +: `GPP_TRIG_W] = trig_r;
      rd_word[`GPP_PRIO_LSB +: PRIO_W] = prio_r;
      rd_word[`GPP_WAKE_LSB +: `GPP_WAKE_W] = wake_r;
    end else if (reg_hit(addr, `GPP_OFS_IRQSTAT)) begin
      rd_word[`GPP_STAT_PEND_BIT] = tif.pending;
      rd_word[`GPP_STAT_HIT_BIT] = tif.hit;
    end
  end

  // Read data register, valid only in the cycle after the strobe
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      rdata_r <= '0;
    end else if (ce) begin
      rdata_r <= rd_en ? rd_word : '0;
    end
  end

  assign rdata = rdata_r;

  // Checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n || !ce);

  sequence s_rd_in;
    rd_en && reg_hit(addr, `GPP_OFS_IN) && mode_r == GPP_MODE_IN;
  endsequence
  sequence s_wr_out;
    wr_en && reg_hit(addr, `GPP_OFS_OUT);
  endsequence

  property p_rd_in;
    s_rd_in |=> rdata[0] == $past(pad_sync);
  endproperty
  a_rd_in: assert property (p_rd_in) else $error("input read mismatch");

  property p_wr_bool;
    s_wr_out |=> out_buf_r == ($past(wdata) != '0);
  endproperty
  a_wr_bool: assert property (p_wr_bool) else $error("level write not reduced");

  property p_in_released;
    mode_r == GPP_MODE_IN |-> !pad_oe;
  endproperty
  a_in_released: assert property (p_in_released) else $error("pad driven in input mode");

  property p_pp_drive;
    s_wr_out ##0 mode_r == GPP_MODE_PP && !wr_ctrl |=> pad_oe && pad_out == ($past(wdata) != '0);
  endproperty
  a_pp_drive: assert property (p_pp_drive) else $error("push-pull write not driven");

  property p_od_drive;
    mode_r == GPP_MODE_OD |-> pad_oe == !out_buf_r && !pad_out;
  endproperty
  a_od_drive: assert property (p_od_drive) else $error("open-drain drive wrong");

  property p_in_to_out;
    mode_r == GPP_MODE_IN ##1 mode_r == GPP_MODE_PP |-> pad_oe && pad_out == out_buf_r;
  endproperty
  a_in_to_out: assert property (p_in_to_out) else $error("buffer not applied");

  property p_rd_buf;
    rd_en && reg_hit(addr, `GPP_OFS_OUT) |=> rdata[0] == $past(out_buf_r);
  endproperty
  a_rd_buf: assert property (p_rd_buf) else $error("buffer readback wrong");

  property p_toggle;
    wr_tog |=> out_buf_r != $past(out_buf_r);
  endproperty
  a_toggle: assert property (p_toggle) else $error("toggle did not invert");

  property p_src_sel;
    (mode_r == GPP_MODE_PP || (mode_r == GPP_MODE_OD && !out_buf_r)) |-> tif.src == out_buf_r;
  endproperty
  a_src_sel: assert property (p_src_sel) else $error("trigger source wrong");

  property p_alt_detach;
    alt_attached ##1 mode_r inside {GPP_MODE_IN, GPP_MODE_PP, GPP_MODE_OD} |-> !alt_attached;
  endproperty
  a_alt_detach: assert property (p_alt_detach) else $error("alternate still attached");

  property p_src_in;
    mode_r == GPP_MODE_IN |-> tif.src == pad_sync;
  endproperty
  a_src_in: assert property (p_src_in) else $error("input trigger source wrong");

  property p_src_od;
    mode_r == GPP_MODE_OD && out_buf_r |-> tif.src == pad_sync;
  endproperty
  a_src_od: assert property (p_src_od) else $error("od trigger source wrong");

  property p_pull_wr;
    wr_ctrl && wdata[`GPP_PULL_LSB +: `GPP_PULL_W] <= GPP_PULL_DOWN
      |=> pull_r == $past(wdata[`GPP_PULL_LSB +: `GPP_PULL_W]);
  endproperty
  a_pull_wr: assert property (p_pull_wr) else $error("pull not written");

  property p_drive_wr;
    wr_ctrl && wdata[`GPP_DRIVE_LSB +: `GPP_DRIVE_W] <= GPP_DRIVE_HIGH
      |=> drive_code == $past(wdata[`GPP_DRIVE_LSB +: `GPP_DRIVE_W]);
  endproperty
  a_drive_wr: assert property (p_drive_wr) else $error("drive code not written");

  property p_prio_wr;
    wr_cfg |=> irq_prio == $past(wdata[`GPP_PRIO_LSB +: PRIO_W]);
  endproperty
  a_prio_wr: assert property (p_prio_wr) else $error("priority not written");

  property p_wake_wr;
    wr_cfg |=> {wake_from_deep_doze, wake_sleep_en, wake_idle_en} ==
      $past(wdata[`GPP_WAKE_LSB +: `GPP_WAKE_W]);
  endproperty
  a_wake_wr: assert property (p_wake_wr) else $error("wake selection not written");
endmodule
`default_nettype wire

// >>> gpp_consts.svh
/*
  Constants for the single GPIO pin cell: register offsets, field
  positions and widths, reset values and synchroniser depth.
  Assumes inclusion by bare name from the cell's source files.
*/
`ifndef GPP_CONSTS_SVH
`define GPP_CONSTS_SVH

// Register offsets, byte addresses on the plain register port
`define GPP_ADDR_W 8
`define GPP_OFS_CTRL 8'h00
`define GPP_OFS_OUT 8'h04
`define GPP_OFS_IN 8'h08
`define GPP_OFS_TOGGLE 8'h0C
`define GPP_OFS_IRQCFG 8'h10
`define GPP_OFS_IRQSTAT 8'h14

// Control register fields
`define GPP_MODE_LSB 0
`define GPP_MODE_W 3
`define GPP_PULL_LSB 4
`define GPP_PULL_W 2
`define GPP_DRIVE_LSB 8
`define GPP_DRIVE_W 2

// Interrupt configuration fields
`define GPP_TRIG_LSB 0
`define GPP_TRIG_W 4
`define GPP_PRIO_LSB 4
`define GPP_WAKE_LSB 8
`define GPP_WAKE_W 3

// Interrupt status bits
`define GPP_STAT_PEND_BIT 0
`define GPP_STAT_HIT_BIT 1

// Level bits of the buffer and pad registers
`define GPP_OUT_BIT 0
`define GPP_IN_BIT 0

// Trigger enable bit positions
`define GPP_TRIG_FALL 0
`define GPP_TRIG_RISE 1
`define GPP_TRIG_LOW 2
`define GPP_TRIG_HIGH 3

// Wake enable bit positions
`define GPP_WAKE_IDLE 0
`define GPP_WAKE_SLEEP 1
`define GPP_WAKE_DEEP 2

// Reset values and synchroniser depth
`define GPP_RST_TRIG 4'h0
`define GPP_RST_WAKE 3'h0
`define GPP_RST_PRIO 1
`define GPP_SYNC_STAGES 2

`endif

// >>> gpp_pkg.sv
/*
  Types shared by the GPIO pin cell: pin mode, pull and drive codes.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package gpp_pkg;
  // Pin mode
  typedef enum logic [2:0] {
    GPP_MODE_IN, GPP_MODE_PP, GPP_MODE_OD, GPP_MODE_ALT, GPP_MODE_ALT_OD
  } gpp_mode_t;
  // Pull resistor selection
  typedef enum logic [1:0] {GPP_PULL_NONE, GPP_PULL_UP, GPP_PULL_DOWN} gpp_pull_t;
  // Drive strength, low to high
  typedef enum logic [1:0] {
    GPP_DRIVE_LOW, GPP_DRIVE_MIDDLE, GPP_DRIVE_HIGH
  } gpp_drive_t;
endpackage

// >>> gpp_trig_if.sv
/*
  Carrier between the pin cell and its trigger detector.
  Assumes both ends run on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
interface gpp_trig_if;
  logic src;
  logic [3:0] trig_en;
  logic clear;
  logic pending;
  logic hit;
  // Cell side
  modport ctl (output src, output trig_en, output clear, input pending, input hit);
  // Detector side
  modport det (input src, input trig_en, input clear, output pending, output hit);
endinterface
`default_nettype wire

// >>> gpp_sync.sv
/*
  Multi-stage synchroniser for the pad input.
  Assumes a single clock; the first stage feeds only the next stage.
*/
`timescale 1ns/1ps
`default_nettype none
`include "gpp_consts.svh"
module gpp_sync #(
  parameter int STAGES = `GPP_SYNC_STAGES
) (
  // Clock and control
  input wire logic clock,
  input wire logic reset_n,
  input wire logic ce,
  // Data
  input wire logic din,
  output logic dout
);
  logic [STAGES-1:0] stage_r;

  // Depth check
  if (STAGES < 2) begin : g_bad
    $error("gpp_sync needs at least two stages");
  end

  // Stage chain, each flop fed only by its predecessor
  for (genvar i = 0; i < STAGES; i++) begin : g_stage
    always_ff @(posedge clock) begin
      if (!reset_n) begin
        stage_r[i] <= 1'b0;
      end else if (ce) begin
        stage_r[i] <= (i == 0) ? din : stage_r[(i == 0) ? 0 : i - 1];
      end
    end
  end

  assign dout = stage_r[STAGES-1];
endmodule
`default_nettype wire

// >>> gpp_trig.sv
/*
  Interrupt trigger detector: edge and level conditions on one source.
  Assumes a synchronous source and a clear pulse from the cell.
*/
`timescale 1ns/1ps
`default_nettype none
`include "gpp_consts.svh"
module gpp_trig (
  // Clock and control
  input wire logic clock,
  input wire logic reset_n,
  input wire logic ce,
  // Trigger carrier
  gpp_trig_if.det t
);
  logic prev_r;
  logic pend_r;
  logic edge_ev;

  // Source history for edge detection
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      prev_r <= 1'b0;
    end else if (ce) begin
      prev_r <= t.src;
    end
  end

  // Enabled edges
  assign edge_ev = (t.trig_en[`GPP_TRIG_RISE] && t.src && !prev_r) ||
                   (t.trig_en[`GPP_TRIG_FALL] && !t.src && prev_r);

  // Sticky edge flag, a new edge beats the clear
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      pend_r <= 1'b0;
    end else if (ce) begin
      if (edge_ev) begin
        pend_r <= 1'b1;
      end else if (t.clear) begin
        pend_r <= 1'b0;
      end
    end
  end

  assign t.pending = pend_r;
  // Any enabled condition raises the request
  assign t.hit = pend_r || (t.trig_en[`GPP_TRIG_LOW] && !t.src) ||
                 (t.trig_en[`GPP_TRIG_HIGH] && t.src);

  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n || !ce);

  property p_pend_hold;
    pend_r && !t.clear |=> pend_r;
  endproperty
  a_pend_hold: assert property (p_pend_hold) else $error("pending edge lost");

  property p_level_hit;
    (t.trig_en[`GPP_TRIG_LOW] && !t.src) || (t.trig_en[`GPP_TRIG_HIGH] && t.src) |-> t.hit;
  endproperty
  a_level_hit: assert property (p_level_hit) else $error("level trigger missed");

  property p_rise_sets;
    t.trig_en[`GPP_TRIG_RISE] && $rose(t.src) |=> pend_r;
  endproperty
  a_rise_sets: assert property (p_rise_sets) else $error("rising edge not held");

  property p_set_wins;
    edge_ev |=> pend_r;
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("edge lost to clear");
endmodule
`default_nettype wire

// >>> gpp_pad_model.sv
/*
  Board side of the pin: resolves the pad level from the cell drive,
  a board driver and the pull selection.
  Assumes the board driver yields whenever the cell drives the pad.
*/
`timescale 1ns/1ps
`default_nettype none
module gpp_pad_model (
  // Clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // Cell side
  input wire logic pad_out,
  input wire logic pad_oe,
  input wire logic pull_up_en,
  input wire logic pull_down_en,
  // Board driver
  input wire logic ext_en,
  input wire logic ext_val,
  // Resolved level
  output logic pad
);
  logic float_r;

  // Undriven, unpulled pad wanders every cycle
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      float_r <= 1'b0;
    end else begin
      float_r <= ~float_r;
    end
  end

  // Cell wins, then board driver, then pulls
  always_comb begin
    if (pad_oe) begin
      pad = pad_out;
    end else if (ext_en) begin
      pad = ext_val;
    end else if (pull_up_en) begin
      pad = 1'b1;
    end else if (pull_down_en) begin
      pad = 1'b0;
    end else begin
      pad = float_r;
    end
  end
endmodule
`default_nettype wire

// >>> tb_top.sv
/*
  Self-checking bench for the pin cell: register port, pad, alternate
  function and interrupt outputs.
  Assumes the cell's package and constants header are compiled first.
*/
`include "gpp_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import gpp_pkg::*;
  logic clock = 1'b0;
  logic reset_n = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic alt_data = 1'b0;
  logic alt_drive_en = 1'b0;
  logic ext_en = 1'b0;
  logic ext_val = 1'b0;
  logic [31:0] rdata;
  logic [31:0] rd_v;
  logic pad, pad_out, pad_oe, pull_up_en, pull_down_en;
  logic alt_attached, irq_req, wake_idle_en, wake_sleep_en, wake_from_deep_doze;
  logic [2:0] irq_prio;
  gpp_drive_t drive_code;
  int miscompares = 0;
  int cmp_count = 0;

  // 50 MHz clock
  always #10 clock = ~clock;

  gpp_top dut_u (.clock(clock), .reset_n(reset_n), .ce(1'b1), .addr(addr),
    .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .pad_in(pad),
    .pad_out(pad_out), .pad_oe(pad_oe), .pull_up_en(pull_up_en),
    .pull_down_en(pull_down_en), .drive_code(drive_code), .alt_data(alt_data),
    .alt_drive_en(alt_drive_en), .alt_attached(alt_attached), .irq_req(irq_req),
    .irq_prio(irq_prio), .wake_idle_en(wake_idle_en), .wake_sleep_en(wake_sleep_en),
    .wake_from_deep_doze(wake_from_deep_doze));

  gpp_pad_model pad_u (.clock(clock), .reset_n(reset_n), .pad_out(pad_out),
    .pad_oe(pad_oe), .pull_up_en(pull_up_en), .pull_down_en(pull_down_en),
    .ext_en(ext_en), .ext_val(ext_val), .pad(pad));

  // Comparison and bus helpers
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge clock);
    wr_en <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clock);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clock);
    rd_en <= 1'b0;
    #1;
    rd_v = rdata;
  endtask
  task automatic ext(input logic en, input logic v);
    @(posedge clock);
    ext_en <= en;
    ext_val <= v;
    repeat (3) @(posedge clock);
    #1;
  endtask
  task automatic wait_irq(input logic v);
    int n;
    n = 0;
    while (irq_req !== v && n < 8) begin
      @(posedge clock);
      #1;
      n++;
    end
    chk(irq_req, v);
  endtask

  // Scenarios
  task automatic t_reset;
    chk({pad_oe, pull_up_en, pull_down_en, drive_code, irq_req}, 6'h00);
    rd(`GPP_OFS_CTRL);
    chk(rd_v, 32'h0);
    rd(`GPP_OFS_OUT);
    chk(rd_v, 32'h0);
    rd(`GPP_OFS_IRQCFG);
    chk(rd_v, 32'h10);
    rd(8'h40);
    chk(rd_v, 32'h0);
  endtask
  task automatic t_input;
    ext(1'b1, 1'b1);
    rd(`GPP_OFS_IN);
    chk(rd_v, 32'h1);
    ext(1'b1, 1'b0);
    rd(`GPP_OFS_IN);
    chk(rd_v, 32'h0);
    wr(`GPP_OFS_OUT, 32'h0000_0100);
    chk({pad_oe, pad}, 2'b00);
    rd(`GPP_OFS_OUT);
    chk(rd_v, 32'h1);
  endtask
  task automatic t_output;
    wr(`GPP_OFS_CTRL, 32'h1);
    chk({pad_oe, pad_out}, 2'b11);
    wr(`GPP_OFS_OUT, 32'h0);
    chk({pad_oe, pad_out}, 2'b10);
    wr(`GPP_OFS_TOGGLE, 32'h0);
    chk(pad_out, 1'b1);
    wr(`GPP_OFS_TOGGLE, 32'h0);
    rd(`GPP_OFS_OUT);
    chk(rd_v, 32'h0);
  endtask
  task automatic t_od;
    wr(`GPP_OFS_CTRL, 32'h2);
    chk({pad_oe, pad_out}, 2'b10);
    wr(`GPP_OFS_OUT, 32'h1);
    chk(pad_oe, 1'b0);
    ext(1'b1, 1'b1);
    rd(`GPP_OFS_IN);
    chk(rd_v, 32'h1);
    ext(1'b1, 1'b0);
    rd(`GPP_OFS_IN);
    chk(rd_v, 32'h0);
  endtask
  task automatic t_cfg;
    for (int p = 0; p < 3; p++) begin
      wr(`GPP_OFS_CTRL, 32'((p << 8) | (p << 4) | p));
      rd(`GPP_OFS_CTRL);
      chk(rd_v, 32'((p << 8) | (p << 4) | p));
      chk({pull_up_en, pull_down_en, drive_code}, {p == 1, p == 2, 2'(p)});
    end
  endtask
  task automatic t_alt;
    @(posedge clock);
    alt_data <= 1'b1;
    alt_drive_en <= 1'b1;
    wr(`GPP_OFS_CTRL, 32'h3);
    chk({alt_attached, pad_oe, pad_out}, 3'b111);
    wr(`GPP_OFS_CTRL, 32'h4);
    chk({alt_attached, pad_oe, pad_out}, 3'b100);
    wr(`GPP_OFS_CTRL, 32'h17);
    rd(`GPP_OFS_CTRL);
    chk(rd_v, 32'h14);
    wr(`GPP_OFS_CTRL, 32'h2);
    chk({alt_attached, pad_oe}, 2'b00);
  endtask
  task automatic t_irq_cfg;
    wr(`GPP_OFS_IRQCFG, 32'h570);
    chk({irq_prio, wake_idle_en, wake_sleep_en, wake_from_deep_doze}, 6'h3D);
    wr(`GPP_OFS_IRQCFG, 32'h200);
    chk({irq_prio, wake_idle_en, wake_sleep_en, wake_from_deep_doze}, 6'h02);
  endtask
  task automatic t_irq_in;
    wr(`GPP_OFS_CTRL, 32'h0);
    ext(1'b1, 1'b1);
    wr(`GPP_OFS_IRQSTAT, 32'h1);
    wr(`GPP_OFS_IRQCFG, 32'h8);
    rd(`GPP_OFS_IRQSTAT);
    chk(rd_v, 32'h2);
    wr(`GPP_OFS_IRQCFG, 32'h0);
    chk(irq_req, 1'b0);
    ext(1'b1, 1'b0);
  endtask
  task automatic t_reset_mid;
    @(posedge clock);
    reset_n <= 1'b0;
    repeat (3) @(posedge clock);
    reset_n <= 1'b1;
    #1;
    t_reset;
  endtask
  task automatic t_irq_edge;
    wr(`GPP_OFS_CTRL, 32'h0);
    wr(`GPP_OFS_IRQSTAT, 32'h1);
    wr(`GPP_OFS_IRQCFG, 32'h2);
    ext(1'b1, 1'b1);
    wait_irq(1'b1);
    ext(1'b1, 1'b0);
    chk(irq_req, 1'b1);
    rd(`GPP_OFS_IRQSTAT);
    chk(rd_v, 32'h3);
    wr(`GPP_OFS_IRQSTAT, 32'h1);
    chk(irq_req, 1'b0);
    wr(`GPP_OFS_IRQCFG, 32'h4);
    wait_irq(1'b1);
    ext(1'b1, 1'b1);
    wait_irq(1'b0);
    wr(`GPP_OFS_IRQCFG, 32'h1);
    ext(1'b1, 1'b0);
    wait_irq(1'b1);
    wr(`GPP_OFS_IRQCFG, 32'h0);
    wr(`GPP_OFS_IRQSTAT, 32'h1);
    chk(irq_req, 1'b0);
  endtask
  task automatic t_irq_src;
    wr(`GPP_OFS_OUT, 32'h1);
    wr(`GPP_OFS_CTRL, 32'h1);
    ext(1'b0, 1'b0);
    wr(`GPP_OFS_IRQCFG, 32'h8);
    wait_irq(1'b1);
    wr(`GPP_OFS_OUT, 32'h0);
    wait_irq(1'b0);
    wr(`GPP_OFS_CTRL, 32'h2);
    wr(`GPP_OFS_IRQCFG, 32'h4);
    wait_irq(1'b1);
    wr(`GPP_OFS_OUT, 32'h1);
    ext(1'b1, 1'b1);
    wait_irq(1'b0);
    ext(1'b1, 1'b0);
    wait_irq(1'b1);
  endtask

  // Verdict and end of run
  task automatic complete_run;
    if (miscompares == 0 && cmp_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // Hang guard, far beyond the few hundred cycles the run needs
  initial begin
    #100000;
    miscompares++;
    complete_run;
  end

  // Main sequence
  initial begin
    repeat (3) @(posedge clock);
    reset_n <= 1'b1;
    #1;
    t_reset;
    t_input;
    t_output;
    t_od;
    t_cfg;
    t_alt;
    t_irq_cfg;
    t_irq_in;
    t_irq_edge;
    t_irq_src;
    t_reset_mid;
    complete_run;
  end
endmodule
`default_nettype wire
